// ### cssc_top.v
/*
 * Clock source and sleep control:
 * source enables, safe clock switching,
 * prescaler, fast clocks, failure monitor,
 * trims, PLL, sleep and clock gating
 * behind an APB slave.
 * Assumes analog oscillators and PLL that
 * report ready and fail levels back.
 */
// Notes on behaviour
// - reset leaves only low power and 2MHz oscillators alive
// - system clock is 2MHz oscillator after reset
// - other sources, calibrators, PLL off at reset
// - source and prescaler change safely anytime
// - prescaler divides one through 2048
// - 4x fast clock from divide four up; 2x clock at base rate only
// - monitored failure gives NMI, internal fallback
// - low power oscillator auto on, 1kHz tap
// - 32.768kHz calibration writable, two outputs
// - calibrators trim 2MHz and 32MHz oscillators
// - 32MHz trim 30-55MHz, 48MHz USB value
// - PLL factor one to 31, lock reported
// - 32.768kHz crystal for system, RTC, calibrator
// - main crystal four modes or external clock
// - sleep instruction enters mode; mode picks wakers
// - wake runs handler, pending higher first
// - CPU halted four cycles after wake
// - state kept in sleep; reset restarts
// - idle stops CPU and NVM only
// - power-down stops all, three wakers only
// - power-save keeps enabled RTC, RTC wakes
// - standby keeps sources; extended keeps RTC
// - gated peripheral clock freezes its state
`include "cssc_defines.vh"

module cssc_top #(
    parameter PR_W = `CSSC_PR_W
) (
    // clock and reset
    input  wire            REF_CLK,
    input  wire            RST,
    // apb slave
    input  wire            PSEL,
    input  wire            PENABLE,
    input  wire            PWRITE,
    input  wire [11:0]     PADDR,
    input  wire [31:0]     PWDATA,
    output wire            PREADY,
    output reg  [31:0]     PRDATA,
    output wire            PSLVERR,
    // oscillator status from analog
    input  wire [`CSSC_SRC_W-1:0] SRC_READY,
    input  wire            XOSC_FAIL,
    input  wire            PLL_LOCK_IN,
    // oscillator controls to analog
    output reg  [`CSSC_SRC_W-1:0] SRC_EN,
    output wire            LOW_POWER_OSC_EN,
    output reg  [2:0]      SYS_SEL,
    output reg  [3:0]      PRESCALE,
    output reg  [4:0]      PLL_FACTOR,
    output reg  [1:0]      PLL_REF,
    output reg  [1:0]      XOSC_MODE,
    output reg             XOSC_EXT_CLK,
    output reg             XOSC32K_LOW_SWING,
    output reg  [5:0]      RC32M_TRIM_MHZ,
    output reg  [7:0]      RC32K_CAL,
    output reg             RC32K_1K_SEL,
    output reg             FLL_REF_XOSC32K,
    output reg             RTC_SRC_XOSC32K,
    // clock enables to the core
    output reg             CPU_CLK_EN,
    output reg             NVM_CLK_EN,
    output reg             PER_CLK_EN,
    output reg             PER2X_CLK_EN,
    output reg             PER4X_CLK_EN,
    output reg             RTC_CLK_EN,
    output reg  [PR_W-1:0] PER_GATE_EN,
    // sleep and wake
    input  wire            SLEEP_EXEC,
    input  wire            ANY_IRQ,
    input  wire [3:0]      WAKE_SRC,
    input  wire            RTC_ENABLED,
    output reg             AWAKE,
    output reg             OSC_NMI
);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    localparam ST_RUN   = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_HALT  = 2'h2;

    reg  [1:0]            st_r;
    reg  [2:0]            halt_r;
    reg  [2:0]            sleep_mode_r;
    reg                   sleep_en_r;
    reg                   fail_mon_r;
    reg  [2:0]            sel_req_r;
    reg  [3:0]            pre_req_r;
    reg  [10:0]           pre_cnt_r;
    reg  [1:0]            fast_cnt_r;
    reg  [7:0]            lock_cnt_r;
    reg                   pll_locked_r;
    reg                   fail_flag_r;
    reg  [PR_W-1:0]       pr_r;

    wire                  wr  = PSEL & PENABLE & PWRITE;
    wire                  rd  = PSEL & ~PENABLE & ~PWRITE;
    // the map is dense up to the fail flag,
    // so a range test decodes every word
    wire                  hit = (PADDR[1:0] == 2'h0) &&
                                (PADDR <= `CSSC_A_FAIL);

    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit;

    // ------------------------------------------------------------
    // source readiness for a selection
    // ------------------------------------------------------------
    function src_ok;
        input [2:0]            sel;
        input [`CSSC_SRC_W-1:0] rdy;
        input                  lk;
        begin
            case (sel)
                `CSSC_SEL_RC2M:    src_ok = rdy[`CSSC_SRC_RC2M];
                `CSSC_SEL_RC32M:   src_ok = rdy[`CSSC_SRC_RC32M];
                `CSSC_SEL_RC32K:   src_ok = rdy[`CSSC_SRC_RC32K];
                `CSSC_SEL_XOSC:    src_ok = rdy[`CSSC_SRC_XOSC];
                `CSSC_SEL_PLL:     src_ok = rdy[`CSSC_SRC_PLL] & lk;
                `CSSC_SEL_XOSC32K: src_ok = rdy[`CSSC_SRC_XOSC32K];
                default:           src_ok = 1'b0;
            endcase
        end
    endfunction

    wire ext_fail  = XOSC_FAIL & ((SYS_SEL == `CSSC_SEL_XOSC) | SRC_EN[`CSSC_SRC_XOSC]);
    wire pll_fail  = pll_locked_r & ~PLL_LOCK_IN & SRC_EN[`CSSC_SRC_PLL];
    wire fail_now  = fail_mon_r & (ext_fail | pll_fail);
    wire pre_wrap  = (pre_cnt_r == ((11'h001 << PRESCALE) - 11'h001));

    // always alive: the watchdog may need it
    // at any time; software cannot stop it
    assign LOW_POWER_OSC_EN = 1'b1;

    // ------------------------------------------------------------
    // register writes and clock source control
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (RST) begin
            SRC_EN            <= `CSSC_SRC_RST;
            SYS_SEL           <= `CSSC_SEL_RC2M;
            sel_req_r         <= `CSSC_SEL_RC2M;
            PRESCALE          <= 4'h0;
            pre_req_r         <= 4'h0;
            PLL_FACTOR        <= `CSSC_PLL_MIN;
            PLL_REF           <= 2'h0;
            XOSC_MODE         <= 2'h0;
            XOSC_EXT_CLK      <= 1'b0;
            XOSC32K_LOW_SWING <= 1'b0;
            RC32M_TRIM_MHZ    <= 6'h20;
            RC32K_CAL         <= `CSSC_CAL_RST;
            RC32K_1K_SEL      <= 1'b0;
            FLL_REF_XOSC32K   <= 1'b0;
            RTC_SRC_XOSC32K   <= 1'b0;
            sleep_mode_r      <= `CSSC_SM_IDLE;
            sleep_en_r        <= 1'b0;
            fail_mon_r        <= 1'b0;
            fail_flag_r       <= 1'b0;
            pr_r              <= {PR_W{1'b0}};
            OSC_NMI           <= 1'b0;
        end else begin
            OSC_NMI <= 1'b0;
            if (wr) begin
                if (PADDR == `CSSC_A_SRC_EN) begin
                    SRC_EN <= PWDATA[`CSSC_SRC_W-1:0];
                end else if (PADDR == `CSSC_A_SYS_SEL) begin
                    sel_req_r <= PWDATA[2:0];
                end else if (PADDR == `CSSC_A_PRESCALE) begin
                    if (PWDATA[3:0] <= `CSSC_PRE_MAX)
                        pre_req_r <= PWDATA[3:0];
                end else if (PADDR == `CSSC_A_PLL) begin
                    if (PWDATA[4:0] != 5'h00)
                        PLL_FACTOR <= PWDATA[4:0];
                    PLL_REF <= PWDATA[9:8];
                end else if (PADDR == `CSSC_A_OSC_CFG) begin
                    XOSC_MODE         <= PWDATA[1:0];
                    XOSC_EXT_CLK      <= PWDATA[2];
                    XOSC32K_LOW_SWING <= PWDATA[3];
                    FLL_REF_XOSC32K   <= PWDATA[4];
                    RTC_SRC_XOSC32K   <= PWDATA[5];
                    fail_mon_r        <= PWDATA[6] | fail_mon_r; // write-once until reset
                    if (PWDATA[7])
                        RC32M_TRIM_MHZ <= `CSSC_RC32M_USB;
                    else if (PWDATA[13:8] >= `CSSC_RC32M_MIN &&
                             PWDATA[13:8] <= `CSSC_RC32M_MAX)
                        RC32M_TRIM_MHZ <= PWDATA[13:8];
                end else if (PADDR == `CSSC_A_CAL32K) begin
                    RC32K_CAL    <= PWDATA[7:0];
                    RC32K_1K_SEL <= PWDATA[8];
                end else if (PADDR == `CSSC_A_SLEEP) begin
                    sleep_en_r   <= PWDATA[0];
                    sleep_mode_r <= PWDATA[3:1];
                end else if (PADDR == `CSSC_A_PWR_RED) begin
                    pr_r <= PWDATA[PR_W-1:0];
                end
            end
            // requested switches go only to a ready source, and only on a prescaler wrap,
            // so no runt pulse reaches the core
            if (pre_wrap) begin
                PRESCALE <= pre_req_r;
                if (sel_req_r != SYS_SEL && src_ok(sel_req_r, SRC_READY, pll_locked_r))
                    SYS_SEL <= sel_req_r;
            end
            // failure wins over a same-cycle clear of the flag
            if (fail_now) begin
                SYS_SEL   <= `CSSC_SEL_RC2M;
                sel_req_r <= `CSSC_SEL_RC2M;
                SRC_EN[`CSSC_SRC_RC2M] <= 1'b1;
                if (!fail_flag_r)
                    OSC_NMI <= 1'b1;
                fail_flag_r <= 1'b1;
            end else if (wr && PADDR == `CSSC_A_FAIL && PWDATA[0]) begin
                fail_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler, fast clock phases, PLL lock
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (RST) begin
            pre_cnt_r    <= 11'h000;
            fast_cnt_r   <= 2'h0;
            lock_cnt_r   <= 8'h00;
            pll_locked_r <= 1'b0;
        end else begin
            pre_cnt_r  <= pre_wrap ? 11'h000 : pre_cnt_r + 11'h001;
            fast_cnt_r <= pre_wrap ? 2'h0 : fast_cnt_r + 2'h1;
            if (!SRC_EN[`CSSC_SRC_PLL] || !PLL_LOCK_IN) begin
                lock_cnt_r   <= 8'h00;
                pll_locked_r <= 1'b0;
            end else if (lock_cnt_r == `CSSC_LOCK_CYC) begin
                pll_locked_r <= 1'b1;
            end else begin
                lock_cnt_r <= lock_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    reg wake_ok;
    always @* begin
        case (sleep_mode_r)
            `CSSC_SM_IDLE:   wake_ok = ANY_IRQ;
            `CSSC_SM_PDOWN,
            `CSSC_SM_STDBY:  wake_ok = WAKE_SRC[`CSSC_WK_TWI] | WAKE_SRC[`CSSC_WK_PORT] |
                                       WAKE_SRC[`CSSC_WK_USB];
            `CSSC_SM_PSAVE,
            `CSSC_SM_ESTDBY: wake_ok = WAKE_SRC[`CSSC_WK_TWI] | WAKE_SRC[`CSSC_WK_PORT] |
                                       WAKE_SRC[`CSSC_WK_USB] |
                                       (RTC_ENABLED & WAKE_SRC[`CSSC_WK_RTC]);
            default:         wake_ok = ANY_IRQ;
        endcase
    end

    // interrupt ordering is the controller's job once the CPU runs again
    always @(posedge REF_CLK) begin
        if (RST) begin
            st_r   <= ST_RUN;
            halt_r <= 3'h0;
        end else begin
            case (st_r)
                ST_RUN: begin
                    if (SLEEP_EXEC && sleep_en_r)
                        st_r <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (wake_ok) begin
                        st_r   <= ST_HALT;
                        halt_r <= 3'h0;
                    end
                end
                ST_HALT: begin
                    if (halt_r == `CSSC_WAKE_HALT - 3'h1)
                        st_r <= ST_RUN;
                    halt_r <= halt_r + 3'h1;
                end
                default: st_r <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock enable outputs
    // ------------------------------------------------------------
    wire in_sleep = (st_r == ST_SLEEP);
    wire per_on   = ~in_sleep | (sleep_mode_r == `CSSC_SM_IDLE);
    wire rtc_on   = ~in_sleep | (sleep_mode_r == `CSSC_SM_IDLE) |
                    (sleep_mode_r == `CSSC_SM_PSAVE) | (sleep_mode_r == `CSSC_SM_ESTDBY);

    genvar g;
    generate
        for (g = 0; g < PR_W; g = g + 1) begin : g_gate
            always @(posedge REF_CLK) begin
                if (RST)
                    PER_GATE_EN[g] <= 1'b0;
                else
                    PER_GATE_EN[g] <= per_on & ~pr_r[g];
            end
        end
    endgenerate

    always @(posedge REF_CLK) begin
        if (RST) begin
            CPU_CLK_EN   <= 1'b0;
            NVM_CLK_EN   <= 1'b0;
            PER_CLK_EN   <= 1'b0;
            PER2X_CLK_EN <= 1'b0;
            PER4X_CLK_EN <= 1'b0;
            RTC_CLK_EN   <= 1'b0;
            AWAKE        <= 1'b0;
        end else begin
            CPU_CLK_EN   <= (st_r == ST_RUN) & pre_wrap;
            NVM_CLK_EN   <= (st_r == ST_RUN) & pre_wrap;
            PER_CLK_EN   <= per_on & pre_wrap;
            PER2X_CLK_EN <= per_on & (pre_wrap | (fast_cnt_r == 2'h1 && PRESCALE == 4'h1) |
                            (PRESCALE >= 4'h2 && pre_cnt_r[PRESCALE-4'h1 -: 1] == 1'b1 &&
                             pre_cnt_r == (11'h001 << (PRESCALE - 4'h1)) - 11'h001));
            PER4X_CLK_EN <= per_on & ((PRESCALE <= 4'h2) |
                            ((pre_cnt_r & ((11'h001 << (PRESCALE - 4'h2)) - 11'h001)) ==
                             ((11'h001 << (PRESCALE - 4'h2)) - 11'h001)));
            RTC_CLK_EN   <= rtc_on & RTC_ENABLED;
            AWAKE        <= (st_r == ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // apb read data, taken in the setup cycle
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
        end else if (rd) begin
            if (PADDR == `CSSC_A_SRC_EN)
                PRDATA <= {24'h000000, SRC_EN};
            else if (PADDR == `CSSC_A_SYS_SEL)
                PRDATA <= {21'h000000, SYS_SEL, 5'h00, sel_req_r};
            else if (PADDR == `CSSC_A_PRESCALE)
                PRDATA <= {24'h000000, PRESCALE, pre_req_r};
            else if (PADDR == `CSSC_A_PLL)
                PRDATA <= {22'h000000, PLL_REF, 3'h0, PLL_FACTOR};
            else if (PADDR == `CSSC_A_OSC_CFG)
                PRDATA <= {18'h00000, RC32M_TRIM_MHZ, 1'b0, fail_mon_r, RTC_SRC_XOSC32K,
                           FLL_REF_XOSC32K, XOSC32K_LOW_SWING, XOSC_EXT_CLK, XOSC_MODE};
            else if (PADDR == `CSSC_A_CAL32K)
                PRDATA <= {23'h000000, RC32K_1K_SEL, RC32K_CAL};
            else if (PADDR == `CSSC_A_SLEEP)
                PRDATA <= {28'h0000000, sleep_mode_r, sleep_en_r};
            else if (PADDR == `CSSC_A_PWR_RED)
                PRDATA <= {{(32-PR_W){1'b0}}, pr_r};
            else if (PADDR == `CSSC_A_STATUS)
                PRDATA <= {22'h000000, pll_locked_r, st_r[0], SRC_READY};
            else if (PADDR == `CSSC_A_FAIL)
                PRDATA <= {31'h00000000, fail_flag_r};
            else
                PRDATA <= 32'h00000000;
        end
    end

endmodule // cssc_top

// ### cssc_defines.vh
/*
 * Constants of the clock and sleep control block:
 * offsets, fields, resets, codes and counts.
 * Assumes inclusion by bare name.
 */
`ifndef CSSC_DEFINES_VH
`define CSSC_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CSSC_A_SRC_EN      12'h000
`define CSSC_A_SYS_SEL     12'h004
`define CSSC_A_PRESCALE    12'h008
`define CSSC_A_PLL         12'h00C
`define CSSC_A_OSC_CFG     12'h010
`define CSSC_A_CAL32K      12'h014
`define CSSC_A_SLEEP       12'h018
`define CSSC_A_PWR_RED     12'h01C
`define CSSC_A_STATUS      12'h020
`define CSSC_A_FAIL        12'h024

// ------------------------------------------------------------
// clock source enable bits (low_power_osc is not software owned)
// ------------------------------------------------------------
`define CSSC_SRC_RC2M      0
`define CSSC_SRC_RC32M     1
`define CSSC_SRC_RC32K     2
`define CSSC_SRC_XOSC32K   3
`define CSSC_SRC_XOSC      4
`define CSSC_SRC_PLL       5
`define CSSC_SRC_FLL2M     6
`define CSSC_SRC_FLL32M    7
`define CSSC_SRC_W         8
`define CSSC_SRC_RST       8'h01

// ------------------------------------------------------------
// system clock selections
// ------------------------------------------------------------
`define CSSC_SEL_RC2M      3'h0
`define CSSC_SEL_RC32M     3'h1
`define CSSC_SEL_RC32K     3'h2
`define CSSC_SEL_XOSC      3'h3
`define CSSC_SEL_PLL       3'h4
`define CSSC_SEL_XOSC32K   3'h5

// ------------------------------------------------------------
// sleep modes
// ------------------------------------------------------------
`define CSSC_SM_IDLE       3'h0
`define CSSC_SM_PDOWN      3'h2
`define CSSC_SM_PSAVE      3'h3
`define CSSC_SM_STDBY      3'h6
`define CSSC_SM_ESTDBY     3'h7

// ------------------------------------------------------------
// misc fields and counts
// ------------------------------------------------------------
`define CSSC_PRE_W         4
`define CSSC_PRE_MAX       4'hB
`define CSSC_PLL_MAX       5'h1F
`define CSSC_PLL_MIN       5'h01
`define CSSC_RC32M_MIN     6'h1E
`define CSSC_RC32M_MAX     6'h37
`define CSSC_RC32M_USB     6'h30
`define CSSC_CAL_RST       8'h80
`define CSSC_WAKE_HALT     3'h4
`define CSSC_LOCK_CYC      8'h40
`define CSSC_PR_W          8
`define CSSC_WK_TWI        0
`define CSSC_WK_PORT       1
`define CSSC_WK_USB        2
`define CSSC_WK_RTC        3

`endif

// ### cssc_top_sva.sv
/* port assertions for cssc_top.
   assumes one clock, synchronous reset. */
module cssc_chk (
    // clock and reset
    input wire       REF_CLK,
    input wire       RST,
    // watched outputs
    input wire [7:0] SRC_EN,
    input wire       LOW_POWER_OSC_EN,
    input wire [2:0] SYS_SEL,
    input wire [3:0] PRESCALE,
    input wire [4:0] PLL_FACTOR,
    input wire [5:0] RC32M_TRIM_MHZ,
    input wire       CPU_CLK_EN,
    input wire       PER2X_CLK_EN,
    input wire       PER4X_CLK_EN,
    input wire       AWAKE,
    input wire       OSC_NMI
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    sequence s_nmi_pulse;
        OSC_NMI ##1 !OSC_NMI;
    endsequence
    sequence s_fallback;
        ##[0:1000] SYS_SEL == 3'h0;
    endsequence
    AST_RST_STATE: assert property (
        $past(RST) |-> SRC_EN == 8'h01 && SYS_SEL == 3'h0) else $error("bad reset state");
    AST_LPO_ON: assert property (
        LOW_POWER_OSC_EN) else $error("low power osc off");
    AST_PRE_RANGE: assert property (
        PRESCALE <= 4'hB) else $error("prescale above 2048");
    AST_PLL_RANGE: assert property (
        $changed(PLL_FACTOR) |-> PLL_FACTOR != 5'h00) else $error("pll factor zero");
    AST_TRIM_RANGE: assert property (
        $changed(RC32M_TRIM_MHZ) |-> RC32M_TRIM_MHZ inside {[6'h1E:6'h37]})
        else $error("trim out of range");
    AST_FAST_CLK: assert property (
        CPU_CLK_EN |-> PER2X_CLK_EN && PER4X_CLK_EN) else $error("fast clock missing");
    AST_NMI_PULSE: assert property (
        $rose(OSC_NMI) |-> s_nmi_pulse) else $error("nmi not one cycle");
    AST_NMI_FALLBACK: assert property (
        OSC_NMI |-> s_fallback) else $error("no fallback to 2MHz");
    AST_SLEEP_STOP: assert property (
        !AWAKE && !$past(AWAKE) |-> !CPU_CLK_EN) else $error("cpu clock while asleep");
    AST_WAKE_HALT: assert property (
        $rose(AWAKE) && !$past(RST, 3) |-> !$past(AWAKE, 4) && !$past(AWAKE, 2))
        else $error("halt too short");
endmodule // cssc_chk

bind cssc_top cssc_chk cssc_chk_inst (.REF_CLK, .RST, .SRC_EN, .LOW_POWER_OSC_EN, .SYS_SEL,
    .PRESCALE, .PLL_FACTOR, .RC32M_TRIM_MHZ, .CPU_CLK_EN, .PER2X_CLK_EN, .PER4X_CLK_EN,
    .AWAKE, .OSC_NMI);

// ### cssc_osc_model.sv
/* oscillator and PLL model.
   assumes bench-driven slow start and failure. */
module cssc_osc_model (
    // clock and commands
    input  wire logic       clk,
    input  wire logic [7:0] src_en,
    input  wire logic       fail_cmd,
    input  wire logic       slow,
    // status to the block
    output logic      [7:0] src_ready,
    output logic            xosc_fail,
    output logic            pll_lock
);
    logic [7:0] st_r [4];
    always @(posedge clk) begin
        st_r[0] <= src_en;
        for (int i = 1; i < 4; i++) st_r[i] <= st_r[i-1] & src_en;
    end
    // ready drops at once on disable; a failed crystal never reads ready
    assign src_ready = src_en & (slow ? st_r[3] : st_r[0]) & ~{3'h0, xosc_fail, 4'h0};
    assign xosc_fail = fail_cmd & src_en[4];
    assign pll_lock  = src_ready[5];
endmodule // cssc_osc_model

// ### tb_cssc_top.sv
/* self-checking bench with queued apb checks.
   assumes cssc_osc_model as analog. */
module tb_cssc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        REF_CLK = '0, RST = '1, PSEL = '0, PENABLE = '0, PWRITE = '0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA;
    logic        SLEEP_EXEC = '0, ANY_IRQ = '0, RTC_ENABLED = '1, fail_cmd = '0, slow = '0;
    logic [3:0]  WAKE_SRC = '0, PRESCALE;
    logic [7:0]  SRC_READY, SRC_EN, RC32K_CAL, PER_GATE_EN;
    logic [5:0]  RC32M_TRIM_MHZ;
    logic [4:0]  PLL_FACTOR;
    logic [2:0]  SYS_SEL;
    logic [1:0]  XOSC_MODE;
    logic        PREADY, PSLVERR, XOSC_FAIL, PLL_LOCK_IN, LOW_POWER_OSC_EN, FLL_REF_XOSC32K;
    logic        RTC_SRC_XOSC32K, CPU_CLK_EN, RTC_CLK_EN, AWAKE, OSC_NMI;
    logic [33:0] q[$];
    int          err_total = 0, cmp_count = 0;
    logic [2:0]  sm [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
    logic [3:0]  wk [5] = '{4'h0, 4'h1, 4'h8, 4'h4, 4'h8};
    logic [3:0]  nw [5] = '{4'h0, 4'h8, 4'h0, 4'h8, 4'h0};
    logic [5:0]  tv [5] = '{6'h1D, 6'h1E, 6'h37, 6'h38, 6'h20};
    cssc_top cssc_top_inst (.REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PREADY, .PRDATA, .PSLVERR, .SRC_READY, .XOSC_FAIL, .PLL_LOCK_IN, .SRC_EN,
        .LOW_POWER_OSC_EN, .SYS_SEL, .PRESCALE, .PLL_FACTOR, .PLL_REF(), .XOSC_MODE,
        .XOSC_EXT_CLK(), .XOSC32K_LOW_SWING(), .RC32M_TRIM_MHZ, .RC32K_CAL, .RC32K_1K_SEL(),
        .FLL_REF_XOSC32K, .RTC_SRC_XOSC32K, .CPU_CLK_EN, .NVM_CLK_EN(), .PER_CLK_EN(),
        .PER2X_CLK_EN(), .PER4X_CLK_EN(), .RTC_CLK_EN, .PER_GATE_EN, .SLEEP_EXEC,
        .ANY_IRQ, .WAKE_SRC, .RTC_ENABLED, .AWAKE, .OSC_NMI);
    cssc_osc_model cssc_osc_model_inst (.clk(REF_CLK), .src_en(SRC_EN), .fail_cmd, .slow,
        .src_ready(SRC_READY), .xosc_fail(XOSC_FAIL), .pll_lock(PLL_LOCK_IN));
    initial forever #2 REF_CLK = ~REF_CLK;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task expire;
        err_total++;
        $display("BAD %0t wait ran out", $time);
        summarize;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int n = 0; n < 3000 && s !== v; n++) @(negedge REF_CLK);
        if (s !== v) expire;
    endtask
    // one transfer; the monitor checks it at the access edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        @(posedge REF_CLK);
        PSEL <= '1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        q.push_back({~w, a > 12'h024, e});
        @(posedge REF_CLK) PENABLE <= '1;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n == 50) expire;
        PSEL <= '0;
        PENABLE <= '0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb('1, a, d, '0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb('0, a, '0, e);
    endtask
    task rst;
        @(posedge REF_CLK) RST <= '1;
        repeat (3) @(posedge REF_CLK);
        RST <= '0;
    endtask
    task nap;
        @(posedge REF_CLK) SLEEP_EXEC <= '1;
        @(posedge REF_CLK) SLEEP_EXEC <= '0;
        wt(AWAKE, '0);
    endtask
    always @(posedge REF_CLK) begin
        if (PSEL && PENABLE && PREADY && q.size() > 0) begin
            chk(32'(PSLVERR), 32'(q[0][32]));
            if (q[0][33]) chk(PRDATA, q[0][31:0]);
            void'(q.pop_front());
        end
    end
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [31:0] r;
        logic [5:0] te;
        logic [7:0] s;
        void'($urandom(32'h2E78FE1D));
        rst;
        @(negedge REF_CLK);
        chk(32'(SRC_EN), 32'h1);
        chk(32'(LOW_POWER_OSC_EN), 32'h1);
        rd(12'h000, 32'h1);
        rd(12'h004, 32'h0);
        rd(12'h014, 32'h80);
        r = $urandom & 32'hFF;
        wr(12'h014, r | 32'h100);
        rd(12'h014, r | 32'h100);
        wr(12'h008, 32'hC);
        rd(12'h008, 32'h0);
        wr(12'h008, 32'hB);
        for (n = 0; n < 5000 && PRESCALE !== 4'hB; n++) @(negedge REF_CLK);
        if (n == 5000) expire;
        rd(12'h008, 32'hBB);
        wt(CPU_CLK_EN, '1);
        @(negedge REF_CLK);
        for (n = 1; n < 5000 && !CPU_CLK_EN; n++) @(negedge REF_CLK);
        chk(n, 2048);
        wr(12'h008, 32'h0);
        for (n = 0; n < 5000 && PRESCALE !== 4'h0; n++) @(negedge REF_CLK);
        if (n == 5000) expire;
        wr(12'h00C, 32'h1F);
        wr(12'h00C, 32'h0);
        chk(32'(PLL_FACTOR), 32'h1F);
        @(posedge REF_CLK) slow <= '1;
        wr(12'h000, 32'h21);
        repeat (80) @(posedge REF_CLK);
        rd(12'h020, 32'h221);
        tv[4] = 6'(30 + $urandom % 26);
        te = 6'h20;
        for (n = 0; n < 5; n++) begin
            wr(12'h010, {18'h0, tv[n], 8'h70} | 32'(n % 4));
            if (tv[n] >= 6'h1E && tv[n] <= 6'h37) te = tv[n];
            @(negedge REF_CLK);
            chk(32'(RC32M_TRIM_MHZ), 32'(te));
            chk(32'(XOSC_MODE), 32'(n % 4));
            chk({30'h0, FLL_REF_XOSC32K, RTC_SRC_XOSC32K}, 32'h3);
        end
        wr(12'h010, 32'hF0);
        @(negedge REF_CLK);
        chk(32'(RC32M_TRIM_MHZ), 32'h30);
        for (n = 0; n < 5; n++) begin
            wr(12'h018, {28'h0, sm[n], 1'b1});
            s = SRC_EN;
            nap;
            if (n > 0) chk(32'(RTC_CLK_EN), 32'(n == 2 || n == 4));
            if (n == 3) chk(32'(SRC_EN), 32'(s));
            @(posedge REF_CLK) ANY_IRQ <= n > 0;
            WAKE_SRC <= nw[n];
            repeat (10) @(negedge REF_CLK);
            chk(32'(AWAKE), 32'h0);
            @(posedge REF_CLK) ANY_IRQ <= '1;
            WAKE_SRC <= wk[n];
            wt(AWAKE, '1);
            @(posedge REF_CLK) ANY_IRQ <= '0;
            WAKE_SRC <= '0;
        end
        rd(12'h014, r | 32'h100);
        wr(12'h018, 32'h5);
        nap;
        rst;
        wt(AWAKE, '1);
        chk(32'(SRC_EN), 32'h1);
        rd(12'h014, 32'h80);
        wr(12'h010, 32'h2040);
        wr(12'h000, 32'h11);
        wr(12'h004, 32'h3);
        for (n = 0; n < 500 && SYS_SEL !== 3'h3; n++) @(negedge REF_CLK);
        if (n == 500) expire;
        @(posedge REF_CLK) fail_cmd <= '1;
        wt(OSC_NMI, '1);
        for (n = 0; n < 50 && SYS_SEL !== 3'h0; n++) @(negedge REF_CLK);
        chk(32'(SYS_SEL), 32'h0);
        @(posedge REF_CLK) fail_cmd <= '0;
        rd(12'h024, 32'h1);
        wr(12'h024, 32'h1);
        rd(12'h024, 32'h0);
        r = $urandom;
        wr(12'h01C, r & 32'hFF);
        repeat (2) @(negedge REF_CLK);
        chk(32'(PER_GATE_EN), {24'h0, ~r[7:0]});
        wr(12'h040, r);
        rd(12'h040, 32'h0);
        summarize;
    end
endmodule // tb_cssc_top
